// ===== hdl/rps_consts.vh
// constants for the receiver reset and power sequencer
// assumes a 100 MHz core clock and a synchronous active-high reset
// Overview of operation
// RQ1 - power-on low: regulators off, power-down
// RQ2 - power-on rise: digital regulators, bias, reset
// RQ3 - analog regulator on only while RF active
// RQ4 - brownout below threshold forces full reset
// RQ5 - interrupt output low while in brownout band
// RQ6 - recovery: high pulse, then hold reset
// RQ7 - reset exit: status all ones, interrupt low
// RQ8 - after reset start in sleep, accept commands
// RQ9 - first status read releases interrupt high
// RQ10 - sleep or polling off: oscillator low power
// RQ11 - wake: oscillator settle, analog, then ready
// RQ12 - combined reset, held by duration counter
// RQ13 - settle and startup waits are counters
`ifndef RPS_CONSTS_VH
`define RPS_CONSTS_VH
`define RPS_CLK_MHZ 100
`define RPS_RESET_NS 1000
`define RPS_RESET_CYC ((`RPS_RESET_NS * `RPS_CLK_MHZ + 999) / 1000)
`define RPS_PULSE_CYC 4
`define RPS_CNT_W 16
`define RPS_STATUS_ONES 8'hff
`define RPS_OSC_SETTLE_DEF 16'h0100
`define RPS_RF_START_DEF 16'h0080
`define RPS_ST_OFF 3'h0
`define RPS_ST_PULSE 3'h1
`define RPS_ST_RESET 3'h2
`define RPS_ST_SLEEP 3'h3
`define RPS_ST_SETTLE 3'h4
`define RPS_ST_START 3'h5
`define RPS_ST_READY 3'h6
`endif

// ===== hdl/rps_sequencer.v
// reset, brownout and sleep/wake sequencing for the receiver core
// assumes power-on pin, brownout flags and commands synchronous to clock
`timescale 1ns/1ns
`include "rps_consts.vh"
module rps_sequencer #(
   parameter [`RPS_CNT_W-1:0] OSC_SETTLE_CYC = `RPS_OSC_SETTLE_DEF,
   parameter [`RPS_CNT_W-1:0] RF_START_CYC = `RPS_RF_START_DEF
)(
   input wire clock,
   input wire sys_rst,
   input wire clkEn,
   input wire powerOn,
   input wire brownoutLow,
   input wire belowFunctional,
   input wire wakeRequest,
   input wire sleepRequest,
   input wire pollingOffPhase,
   input wire statusRead,
   input wire [7:0] clearMask0,
   input wire [7:0] clearMask1,
   input wire [7:0] eventSet0,
   input wire [7:0] eventSet1,
   output reg [7:0] irqStatus0,
   output reg [7:0] irqStatus1,
   output reg interruptOut_n,
   output reg digitalRegEn,
   output reg biasEn,
   output reg analogRegEn,
   output reg rfSynthEn,
   output reg oscLowPower,
   output reg loadCapsOn,
   output reg rxReady,
   output reg coreReset,
   output wire cmdAccept
);
   localparam [`RPS_CNT_W-1:0] RESET_CYC = `RPS_RESET_CYC;
   localparam [`RPS_CNT_W-1:0] PULSE_CYC = `RPS_PULSE_CYC;
   reg [2:0] state;
   reg [2:0] next_state;
   reg [`RPS_CNT_W-1:0] count;
   reg [`RPS_CNT_W-1:0] next_count;
   reg powerOnPrev;
   reg firstReadPending;
   reg inBrownout;
   wire powerRise;
   wire countDone;
   wire enteringSleep;
   assign powerRise = powerOn & ~powerOnPrev; // RQ2
   assign countDone = (count == {`RPS_CNT_W{1'b0}});
   // commands only honoured once the core is out of reset
   assign cmdAccept = (state == `RPS_ST_SLEEP) ||
      (state == `RPS_ST_SETTLE) || (state == `RPS_ST_START) ||
      (state == `RPS_ST_READY); // RQ8
   assign enteringSleep = (state == `RPS_ST_READY) &&
      (sleepRequest | pollingOffPhase);

   always @*
   begin
      next_state = state;
      next_count = countDone ? count : count - 1'b1;
      case (state)
         `RPS_ST_OFF:
         begin
            if (powerRise) // RQ2
            begin
               next_state = `RPS_ST_RESET;
               next_count = RESET_CYC; // RQ12
            end
         end
         `RPS_ST_PULSE:
         begin
            if (countDone)
            begin
               next_state = `RPS_ST_RESET; // RQ6
               next_count = RESET_CYC;
            end
         end
         `RPS_ST_RESET:
         begin
            if (countDone)
               next_state = `RPS_ST_SLEEP; // RQ8
         end
         `RPS_ST_SLEEP:
         begin
            if (wakeRequest & ~pollingOffPhase & ~sleepRequest)
            begin
               next_state = `RPS_ST_SETTLE; // RQ11
               next_count = OSC_SETTLE_CYC; // RQ13
            end
         end
         `RPS_ST_SETTLE:
         begin
            if (sleepRequest | pollingOffPhase)
               next_state = `RPS_ST_SLEEP;
            else if (countDone)
            begin
               next_state = `RPS_ST_START; // RQ11
               next_count = RF_START_CYC; // RQ13
            end
         end
         `RPS_ST_START:
         begin
            if (sleepRequest | pollingOffPhase)
               next_state = `RPS_ST_SLEEP;
            else if (countDone)
               next_state = `RPS_ST_READY; // RQ11
         end
         `RPS_ST_READY:
         begin
            if (enteringSleep)
               next_state = `RPS_ST_SLEEP; // RQ10
         end
         default:
         begin
            next_state = `RPS_ST_OFF;
         end
      endcase
      // brownout overrides every state; power-off overrides brownout
      if (inBrownout)
      begin
         next_state = brownoutLow ? `RPS_ST_RESET : `RPS_ST_PULSE; // RQ4
         next_count = brownoutLow ? RESET_CYC : PULSE_CYC; // RQ6
      end
      if (!powerOn)
         next_state = `RPS_ST_OFF; // RQ1
   end

   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         state <= `RPS_ST_OFF;
         count <= {`RPS_CNT_W{1'b0}};
         powerOnPrev <= 1'b0;
         inBrownout <= 1'b0;
         firstReadPending <= 1'b0;
         irqStatus0 <= 8'h00;
         irqStatus1 <= 8'h00;
         interruptOut_n <= 1'b1;
         digitalRegEn <= 1'b0;
         biasEn <= 1'b0;
         analogRegEn <= 1'b0;
         rfSynthEn <= 1'b0;
         oscLowPower <= 1'b1;
         loadCapsOn <= 1'b0;
         rxReady <= 1'b0;
         coreReset <= 1'b1;
      end
      else if (clkEn)
      begin
         powerOnPrev <= powerOn;
         // brownout latched until supply recovers; first cycle back pulses
         inBrownout <= powerOn & brownoutLow; // RQ4
         state <= next_state;
         count <= next_count;
         digitalRegEn <= powerOn; // RQ1
         biasEn <= powerOn; // RQ1
         coreReset <= (next_state == `RPS_ST_OFF) ||
            (next_state == `RPS_ST_PULSE) ||
            (next_state == `RPS_ST_RESET); // RQ12
         analogRegEn <= (next_state == `RPS_ST_START) ||
            (next_state == `RPS_ST_READY); // RQ3
         rfSynthEn <= (next_state == `RPS_ST_START) ||
            (next_state == `RPS_ST_READY); // RQ11
         rxReady <= (next_state == `RPS_ST_READY); // RQ11
         oscLowPower <= ~((next_state == `RPS_ST_SETTLE) ||
            (next_state == `RPS_ST_START) ||
            (next_state == `RPS_ST_READY)); // RQ10
         loadCapsOn <= (next_state == `RPS_ST_SETTLE) ||
            (next_state == `RPS_ST_START) ||
            (next_state == `RPS_ST_READY); // RQ10
         if (state == `RPS_ST_RESET && next_state == `RPS_ST_SLEEP)
         begin
            irqStatus0 <= `RPS_STATUS_ONES; // RQ7
            irqStatus1 <= `RPS_STATUS_ONES; // RQ7
            interruptOut_n <= 1'b0; // RQ7
            firstReadPending <= 1'b1;
         end
         else if (next_state == `RPS_ST_PULSE)
            interruptOut_n <= 1'b1; // RQ6
         else if (brownoutLow & ~belowFunctional)
            interruptOut_n <= 1'b0; // RQ5
         else if (coreReset)
            interruptOut_n <= interruptOut_n;
         else
         begin
            // new events win over a same-cycle clear
            irqStatus0 <= (irqStatus0 & ~clearMask0) | eventSet0;
            irqStatus1 <= (irqStatus1 & ~clearMask1) | eventSet1;
            if (statusRead & firstReadPending)
            begin
               interruptOut_n <= 1'b1; // RQ9
               firstReadPending <= 1'b0;
            end
         end
      end
   end
endmodule

// ===== sim/rps_sequencer_sva.sv
// checker on the sequencer ports
// assumes clkEn is held high
`timescale 1ns/1ns
module rps_sequencer_sva (
   input wire clock, sys_rst, powerOn, brownoutLow, belowFunctional,
   input wire statusRead, interruptOut_n, digitalRegEn, biasEn, rxReady,
   input wire analogRegEn, rfSynthEn, oscLowPower, loadCapsOn,
   input wire coreReset, cmdAccept,
   input wire [7:0] irqStatus0, irqStatus1
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   a_off_regs_off: assert property (!powerOn |=> !digitalRegEn && !biasEn
      && !analogRegEn) else $error("regulator on while off");
   a_rise_reset: assert property ($rose(powerOn) |-> ##[1:2]
      (coreReset && digitalRegEn && biasEn)) else $error("no reset");
   a_analog_gated: assert property (analogRegEn |-> !coreReset
      && !oscLowPower) else $error("analog on early");
   a_brown_reset: assert property (brownoutLow && powerOn |-> ##[1:3]
      coreReset) else $error("brownout kept running");
   a_band_int: assert property ((brownoutLow && powerOn && !belowFunctional)
      [*4] |-> !interruptOut_n) else $error("pin high in band");
   a_recover_pulse: assert property ((brownoutLow && powerOn)[*4] ##1
      (!brownoutLow && powerOn) |-> ##[1:3] interruptOut_n)
      else $error("no recovery pulse");
   a_exit_ones: assert property ($fell(coreReset) |-> irqStatus0 == 8'hff
      && irqStatus1 == 8'hff && !interruptOut_n && cmdAccept)
      else $error("bad reset exit");
   a_read_release: assert property (statusRead && !coreReset && powerOn
      && !brownoutLow |=> interruptOut_n) else $error("pin held");
   a_caps_follow: assert property (loadCapsOn == !oscLowPower)
      else $error("caps mismatch");
   a_wake_order: assert property ($rose(rxReady) |-> $past(analogRegEn)
      && rfSynthEn) else $error("ready too soon");
   c_exit: cover property ($fell(coreReset));
   c_ready: cover property ($rose(rxReady));
   c_brown: cover property ($fell(brownoutLow) && powerOn);
endmodule
bind rps_sequencer rps_sequencer_sva u_sva (.*);

// ===== sim/rps_mcu_model.sv
// controller model: one status read while the pin is low
// assumes the bench gates reading with rdEn
`timescale 1ns/1ns
module rps_mcu_model (
   input wire clock,
   input wire rdEn,
   input wire interruptOut_n,
   input wire coreReset,
   output reg statusRead
);
   initial statusRead = 1'b0;
   // pulse only, the serial frame is not modelled
   always @(posedge clock)
      statusRead <= #1 rdEn && !interruptOut_n && !coreReset
         && !statusRead;
endmodule

// ===== sim/test_rps_sequencer.sv
// bench for the sequencer with a controller model
// assumes short settle counts so the run stays brief
`timescale 1ns/1ns
module test_rps_sequencer;
   reg clock = 0, sys_rst = 1, clkEn = 1, powerOn = 0, brownoutLow = 0;
   reg belowFunctional = 0, wakeRequest = 0, sleepRequest = 0, rdEn = 0;
   reg pollingOffPhase = 0;
   reg [7:0] clearMask0 = 0, clearMask1 = 0, eventSet0 = 0, eventSet1 = 0;
   reg [16:0] lfsr = 17'h12de7;
   wire statusRead, interruptOut_n, digitalRegEn, biasEn, analogRegEn;
   wire rfSynthEn, oscLowPower, loadCapsOn, rxReady, coreReset, cmdAccept;
   wire [7:0] irqStatus0, irqStatus1;
   integer n_mismatch = 0, check_count = 0, i;
   rps_sequencer #(.OSC_SETTLE_CYC(16'h0004), .RF_START_CYC(16'h0004))
      DUT (.*);
   rps_mcu_model mcu (.*);
   function [16:0] nxt(input [16:0] v);
      nxt = {v[15:0], v[16] ^ v[13]};
   endfunction
   task step(input integer n);
      begin repeat (n) @(posedge clock); #1; end
   endtask
   task chk(input [7:0] seen, input [7:0] want);
   begin
      check_count = check_count + 1;
      if (seen !== want)
      begin
         n_mismatch = n_mismatch + 1;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   end
   endtask
   task waitRst;
      for (i = 0; i < 300 && coreReset !== 1'b0; i = i + 1) step(1);
   endtask
   task conclude;
   begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask
   initial forever #5 clock = ~clock;
   initial
   begin
      #200000;
      n_mismatch = n_mismatch + 1;
      conclude;
   end
   initial
   begin
      step(6); sys_rst = 0; step(3);
      chk(digitalRegEn, 8'h00);
      powerOn = 1; step(2);
      chk({coreReset, digitalRegEn, biasEn}, 8'h07);
      waitRst;
      chk(irqStatus0 & irqStatus1, 8'hff);
      chk({interruptOut_n, cmdAccept, oscLowPower}, 8'h03);
      repeat (4)
      begin
         lfsr = nxt(lfsr); clearMask0 = 8'hff; step(1);
         clearMask0 = 0; eventSet0 = lfsr[7:0]; eventSet1 = lfsr[15:8];
         step(1); eventSet0 = 0; eventSet1 = 0; step(1);
         chk(irqStatus0, lfsr[7:0]);
         chk(irqStatus1, 8'hff);
      end
      rdEn = 1; step(4); rdEn = 0;
      chk(interruptOut_n, 8'h01);
      $display("test power-on done");
      // frozen clock enable must hold sleep even with a wake pending
      clkEn = 0; wakeRequest = 1; sleepRequest = 1; step(3);
      chk({oscLowPower, loadCapsOn, rxReady}, 8'h04);
      // a standing sleep request refuses the wake
      clkEn = 1; step(3);
      chk({oscLowPower, loadCapsOn, cmdAccept}, 8'h05);
      sleepRequest = 0; step(3);
      chk({oscLowPower, loadCapsOn, analogRegEn}, 8'h02);
      for (i = 0; i < 50 && rxReady !== 1'b1; i = i + 1) step(1);
      chk({rxReady, analogRegEn, rfSynthEn, oscLowPower}, 8'h0e);
      wakeRequest = 0; pollingOffPhase = 1; step(3); pollingOffPhase = 0;
      chk({rxReady, analogRegEn, oscLowPower, loadCapsOn}, 8'h02);
      $display("test wake done");
      brownoutLow = 1; step(6);
      chk({coreReset, interruptOut_n}, 8'h02);
      brownoutLow = 0; step(3);
      chk(interruptOut_n, 8'h01);
      waitRst;
      chk({irqStatus0[6:0], interruptOut_n}, 8'hfe);
      $display("test brownout done");
      powerOn = 0; step(2);
      chk({digitalRegEn, biasEn, analogRegEn, coreReset}, 8'h01);
      $display("test power-down done");
      conclude;
   end
endmodule
